// >>> sicr_pkg.sv
// Purpose: shared constants and types for the serial port settings bank
// Assumes: 8-bit register space addressed as printed, one clock domain
// Notes:   offsets, field positions and reset values live only here
// What this block does
// - bit 1 of serial_port_settings picks 3-wire SPI (1) or 4-wire (0), reset 0
// - bit 0 of serial_port_settings enables the I2C port, reset value 1
// - temp format bits 3:2 pick pin behaviour, reset values 1 and 0
// - factory multi-slave option blocks written wire-count and I2C enable
// - soft restore command returns all registers to defaults, no data phase
package sicr_pkg;

	// ========================================================
	// register map
	localparam logic [7:0] SICR_ADDR_TEMP_FMT   = 8'h1C;
	localparam logic [7:0] SICR_ADDR_PORT_SET   = 8'h1F;
	localparam logic [7:0] SICR_CMD_SOFT_RESTORE = 8'h09;

	// ========================================================
	// reset values and writable masks
	localparam logic [7:0] SICR_PORT_SET_RST  = 8'h01;
	localparam logic [7:0] SICR_PORT_SET_WMSK = 8'h03;
	localparam logic [7:0] SICR_TEMP_FMT_RST  = 8'h4B;
	localparam logic [7:0] SICR_TEMP_FMT_WMSK = 8'h7F;
	localparam logic [7:0] SICR_RD_UNMAPPED   = 8'h00;

	// ========================================================
	// field positions
	localparam int SICR_BIT_I2C_EN    = 0;
	localparam int SICR_BIT_WIRE_SEL  = 1;
	localparam int SICR_DOUT_SEL_LO   = 2;
	localparam int SICR_DOUT_SEL_HI   = 3;
	localparam int SICR_TWF_LO        = 5;
	localparam int SICR_TWF_HI        = 6;

	// values applied while the multi-slave option owns the port
	localparam logic SICR_MS_WIRE_SEL = 1'b0;
	localparam logic SICR_MS_I2C_EN   = 1'b0;

	// ========================================================
	// register access request from the serial front end
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic       cmd;
		logic [7:0] addr;
		logic [7:0] data;
	} sicr_req_t;

	// applied settings toward the port logic
	typedef struct packed {
		logic       wire_count_select;
		logic       i2c_enable;
		logic [1:0] dout_pin_behaviour_sel;
		logic [1:0] temp_word_format;
	} sicr_cfg_t;

endpackage

// >>> sicr_sync2.sv
// Purpose: two flip-flop synchroniser for a level from a pin
// Assumes: input is a slow static level
// Notes:   only the second stage may be read by other logic
`timescale 1ns/1ps
module sicr_sync2
(
	// clock and reset
	input  wire logic i_clk,
	input  wire logic i_rst,
	// level in and out
	input  wire logic i_lvl,
	output logic      o_lvl
);
	logic meta_r;
	logic meta_nxt;
	logic sync_r;
	logic sync_nxt;

	// ========================================================
	// next values
	always_comb
	begin
		meta_nxt = i_lvl;
		sync_nxt = meta_r;
	end

	// first stage feeds nothing but the second
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
		end
		else
		begin
			meta_r <= meta_nxt;
			sync_r <= sync_nxt;
		end
	end

	assign o_lvl = sync_r;
endmodule

// >>> sicr_regs.sv
// Purpose: serial port settings and temperature format registers
// Assumes: requests arrive decoded from the serial front end, same clock
// Notes:   multi-slave strap comes from a pin and is synchronised
`timescale 1ns/1ps
module sicr_regs
	import sicr_pkg::*;
(
	// clock and reset
	input  wire logic                I_SYS_CLK,
	input  wire logic                I_RST,
	// decoded register access
	input  wire sicr_pkg::sicr_req_t I_REQ,
	// factory multi-slave strap pin
	input  wire logic                I_MULTI_SLAVE,
	// read data, valid the cycle after a read
	output logic [7:0]               O_RD_DATA,
	output logic                     O_RD_VALID,
	// applied settings
	output sicr_pkg::sicr_cfg_t      O_CFG
);
	import sicr_pkg::*;

	logic [7:0] port_set_r;
	logic [7:0] port_set_nxt;
	logic [7:0] temp_fmt_r;
	logic [7:0] temp_fmt_nxt;
	logic [7:0] rd_data_r;
	logic [7:0] rd_data_nxt;
	logic       rd_valid_r;
	logic       rd_valid_nxt;
	sicr_cfg_t  cfg_r;
	sicr_cfg_t  cfg_nxt;
	logic       multi_slave_s;
	logic       soft_restore;

	// ========================================================
	// strap synchroniser
	sicr_sync2 u_ms_sync
	(
		.i_clk (I_SYS_CLK),
		.i_rst (I_RST),
		.i_lvl (I_MULTI_SLAVE),
		.o_lvl (multi_slave_s)
	);

	// ========================================================
	// register file
	// restore is a bare address: no data phase is needed or used
	assign soft_restore = I_REQ.cmd && (I_REQ.addr == SICR_CMD_SOFT_RESTORE);

	always_comb
	begin
		port_set_nxt = port_set_r;
		temp_fmt_nxt = temp_fmt_r;
		if (soft_restore)
		begin
			port_set_nxt = SICR_PORT_SET_RST;
			temp_fmt_nxt = SICR_TEMP_FMT_RST;
		end
		else if (I_REQ.wr)
		begin
			// reserved interface bits never take host data
			if (I_REQ.addr == SICR_ADDR_PORT_SET)
				port_set_nxt = I_REQ.data & SICR_PORT_SET_WMSK;
			// bit 7 is read only and stays zero
			if (I_REQ.addr == SICR_ADDR_TEMP_FMT)
				temp_fmt_nxt = I_REQ.data & SICR_TEMP_FMT_WMSK;
		end
	end

	always_ff @(posedge I_SYS_CLK)
	begin
		if (I_RST)
		begin
			port_set_r <= SICR_PORT_SET_RST;
			temp_fmt_r <= SICR_TEMP_FMT_RST;
		end
		else
		begin
			port_set_r <= port_set_nxt;
			temp_fmt_r <= temp_fmt_nxt;
		end
	end

	// ========================================================
	// read path, registered so the output comes from a flop
	always_comb
	begin
		rd_valid_nxt = I_REQ.rd;
		rd_data_nxt  = rd_data_r;
		if (I_REQ.rd)
		begin
			case (I_REQ.addr)
				SICR_ADDR_PORT_SET: rd_data_nxt = port_set_r;
				SICR_ADDR_TEMP_FMT: rd_data_nxt = temp_fmt_r;
				default:            rd_data_nxt = SICR_RD_UNMAPPED;
			endcase
		end
	end

	always_ff @(posedge I_SYS_CLK)
	begin
		if (I_RST)
		begin
			rd_data_r  <= SICR_RD_UNMAPPED;
			rd_valid_r <= 1'b0;
		end
		else
		begin
			rd_data_r  <= rd_data_nxt;
			rd_valid_r <= rd_valid_nxt;
		end
	end

	// ========================================================
	// applied settings; one cycle behind the registers
	// the strap overrides the stored wire-count and I2C enable bits, which stay readable
	always_comb
	begin
		cfg_nxt.dout_pin_behaviour_sel =
			temp_fmt_r[SICR_DOUT_SEL_HI:SICR_DOUT_SEL_LO];
		cfg_nxt.temp_word_format =
			temp_fmt_r[SICR_TWF_HI:SICR_TWF_LO];
		if (multi_slave_s)
		begin
			cfg_nxt.wire_count_select = SICR_MS_WIRE_SEL;
			cfg_nxt.i2c_enable        = SICR_MS_I2C_EN;
		end
		else
		begin
			cfg_nxt.wire_count_select = port_set_r[SICR_BIT_WIRE_SEL];
			cfg_nxt.i2c_enable        = port_set_r[SICR_BIT_I2C_EN];
		end
	end

	always_ff @(posedge I_SYS_CLK)
	begin
		if (I_RST)
		begin
			cfg_r.wire_count_select      <= SICR_PORT_SET_RST[SICR_BIT_WIRE_SEL];
			cfg_r.i2c_enable             <= SICR_PORT_SET_RST[SICR_BIT_I2C_EN];
			cfg_r.dout_pin_behaviour_sel <=
				SICR_TEMP_FMT_RST[SICR_DOUT_SEL_HI:SICR_DOUT_SEL_LO];
			cfg_r.temp_word_format <= SICR_TEMP_FMT_RST[SICR_TWF_HI:SICR_TWF_LO];
		end
		else
			cfg_r <= cfg_nxt;
	end

	assign O_RD_DATA  = rd_data_r;
	assign O_RD_VALID = rd_valid_r;
	assign O_CFG      = cfg_r;

	// ========================================================
	// checks
	sequence restore_s;
		I_REQ.cmd && (I_REQ.addr == SICR_CMD_SOFT_RESTORE);
	endsequence

	sequence defaults_s;
		(port_set_r == SICR_PORT_SET_RST) && (temp_fmt_r == SICR_TEMP_FMT_RST);
	endsequence

	property restore_p;
		@(posedge I_SYS_CLK) disable iff (I_RST)
		restore_s |=> defaults_s;
	endproperty

	restore_defaults_a: assert property (restore_p)
		else $error("soft restore did not reload defaults");

	reserved_zero_a: assert property (
		@(posedge I_SYS_CLK) disable iff (I_RST)
		(port_set_r & ~SICR_PORT_SET_WMSK) == 8'h00)
		else $error("reserved interface bits not zero");

	wire_sel_write_a: assert property (
		@(posedge I_SYS_CLK) disable iff (I_RST)
		I_REQ.wr && !I_REQ.cmd && (I_REQ.addr == SICR_ADDR_PORT_SET)
		|=> port_set_r[SICR_BIT_WIRE_SEL] == $past(I_REQ.data[SICR_BIT_WIRE_SEL]))
		else $error("wire count select not stored");

	i2c_applied_a: assert property (
		@(posedge I_SYS_CLK) disable iff (I_RST)
		!multi_slave_s ##1 1'b1
		|-> O_CFG.i2c_enable == $past(port_set_r[SICR_BIT_I2C_EN]))
		else $error("i2c enable not applied");

	dout_sel_applied_a: assert property (
		@(posedge I_SYS_CLK) disable iff (I_RST)
		1'b1 ##1 1'b1 |-> O_CFG.dout_pin_behaviour_sel
			== $past(temp_fmt_r[SICR_DOUT_SEL_HI:SICR_DOUT_SEL_LO]))
		else $error("pin behaviour select not applied");

	multi_slave_a: assert property (
		@(posedge I_SYS_CLK) disable iff (I_RST)
		multi_slave_s |=> (O_CFG.wire_count_select == SICR_MS_WIRE_SEL)
			&& (O_CFG.i2c_enable == SICR_MS_I2C_EN))
		else $error("multi-slave did not override port settings");

	reset_value_a: assert property (
		@(posedge I_SYS_CLK)
		I_RST |=> defaults_s)
		else $error("registers not at defaults after reset");

	read_port_a: assert property (
		@(posedge I_SYS_CLK) disable iff (I_RST)
		I_REQ.rd && (I_REQ.addr == SICR_ADDR_PORT_SET)
		|=> O_RD_VALID && (O_RD_DATA[7:2] == 6'h00))
		else $error("interface read showed reserved bits");
endmodule

// >>> sicr_host_model.sv
// Purpose: host side model issuing register accesses to the bank
// Assumes: same clock as the bank, each request one cycle long
// Notes:   idle address and data show the inverse of the last value
`timescale 1ns/1ps
module sicr_host_model
(
	// clock
	input  wire logic           i_clk,
	// request toward the bank
	output sicr_pkg::sicr_req_t o_req
);
	import sicr_pkg::*;

	// ========================================================
	// request driving
	initial o_req = '0;

	// host speaks spi here, so mode bits may change
	// idle lines flip so a stale value is never mistaken for data
	task automatic send(input logic w, input logic r, input logic c,
		input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk);
		#1;
		o_req = '{wr: w, rd: r, cmd: c, addr: a, data: d};
		@(posedge i_clk);
		#1;
		o_req = '{wr: 1'b0, rd: 1'b0, cmd: 1'b0, addr: ~a, data: ~d};
	endtask
endmodule

// >>> sicr_regs_tb.sv
// Purpose: self-checking bench for the serial port settings bank
// Assumes: host model drives requests just after the rising edge
// Notes:   applied settings are checked two edges after a write
`timescale 1ns/1ps
module sicr_regs_tb;
	import sicr_pkg::*;

	// ========================================================
	// signals
	logic       sys_clk;
	logic       rst;
	logic       multi_slave;
	logic       rd_valid;
	logic [7:0] rd_data;
	sicr_req_t  req;
	sicr_cfg_t  cfg;
	int         fail_count;
	int         compares;

	// clock at 20 MHz
	initial
	begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end

	sicr_host_model u_host (.i_clk(sys_clk), .o_req(req));
	sicr_regs u_dut (.I_SYS_CLK(sys_clk), .I_RST(rst), .I_REQ(req),
		.I_MULTI_SLAVE(multi_slave), .O_RD_DATA(rd_data),
		.O_RD_VALID(rd_valid), .O_CFG(cfg));

	// ========================================================
	// tasks
	task automatic end_sim();
		$display("compares %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp)
		begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// valid should already be up; bounded wait guards a hang
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		int n;
		u_host.send(1'b0, 1'b1, 1'b0, a, 8'h00);
		n = 0;
		while (rd_valid !== 1'b1 && n < 4)
		begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		// a read that never answers ends the run as a failure
		if (n == 4)
		begin
			fail_count++;
			end_sim();
		end
		else
			chk(rd_data, exp);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		u_host.send(1'b1, 1'b0, 1'b0, a, d);
	endtask

	task automatic restore();
		u_host.send(1'b0, 1'b0, 1'b1, SICR_CMD_SOFT_RESTORE, 8'h00);
	endtask

	// settings land two edges after the request
	task automatic cfg_chk(input int cyc, input logic [7:0] exp);
		repeat (cyc) @(posedge sys_clk);
		#1;
		chk({2'b00, cfg}, exp);
	endtask

	// ========================================================
	// main sequence
	initial
	begin
		rst = 1'b1;
		multi_slave = 1'b0;
		fail_count = 0;
		compares = 0;
		repeat (5) @(posedge sys_clk);
		#1;
		rst = 1'b0;
		cfg_chk(0, 8'h1A);
		rd(8'h1F, 8'h01);
		rd(8'h1C, 8'h4B);
		$display("test defaults done");
		wr(8'h1F, 8'hFF);
		cfg_chk(1, 8'h3A);
		rd(8'h1F, 8'h03);
		wr(8'h1F, 8'h02);
		cfg_chk(1, 8'h2A);
		rd(8'h1F, 8'h02);
		$display("test port settings done");
		restore();
		cfg_chk(1, 8'h1A);
		rd(8'h1F, 8'h01);
		wr(8'h1C, 8'h43);
		cfg_chk(1, 8'h12);
		rd(8'h1C, 8'h43);
		restore();
		rd(8'h1C, 8'h4B);
		$display("test restore and pin select done");
		wr(8'h1F, 8'h03);
		multi_slave = 1'b1;
		cfg_chk(4, 8'h0A);
		rd(8'h1F, 8'h03);
		multi_slave = 1'b0;
		cfg_chk(4, 8'h3A);
		rd(8'h10, 8'h00);
		$display("test multi slave done");
		end_sim();
	end
endmodule
